// File: verilog/irq_pkg.sv
package irq_pkg;
    // ********************************************
    // Register indexes (byte address = 4 x index)
    // ********************************************
    localparam logic [5:0] IDX_PEND2 = 6'h14;
    localparam logic [5:0] IDX_PEND3 = 6'h15;
    localparam logic [5:0] IDX_CTRL = 6'h16;
    localparam logic [5:0] IDX_ENA2 = 6'h17;
    localparam logic [5:0] IDX_ENA3 = 6'h18;
    localparam logic [5:0] IDX_PRIO = 6'h19;
    localparam int ADDR_LO = 2;
    localparam int ADDR_HI = 7;

    // ********************************************
    // Control register layout
    // ********************************************
    localparam int CTRL_INT_BIT = 15;
    localparam int CTRL_NEST_HI = 14;
    localparam int CTRL_NEST_LO = 13;
    localparam int CTRL_VAB_HI = 12;
    localparam int CTRL_VAB_LO = 6;
    localparam int CTRL_DIS_BIT = 5;
    localparam logic [4:0] CTRL_RESV = 5'h1c;
    localparam logic [15:0] CTRL_RESET = 16'h001c;

    // ********************************************
    // Vector numbering
    // ********************************************
    localparam int N_WORD2 = 16;
    localparam int N_WORD3 = 15;
    localparam int N_PERIPH = 31;
    localparam int N_EXC = 8;
    localparam logic [5:0] VEC_LO2 = 6'h21;
    localparam logic [5:0] VEC_LO3 = 6'h31;
    localparam logic [5:0] EXC_VEC_FIRST = 6'h01;
    localparam int BASE_W = 14;
    localparam int VAB_W = 21;

    // ********************************************
    // Priority ranks and reset handshake
    // ********************************************
    typedef logic [2:0] rank_t;
    // Rank per exception slot: 0 lowest trap, 4 = level 3
    localparam logic [23:0] EXC_RANKS = {
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};
    localparam rank_t FAST_RANK = 3'h3;
    localparam logic [1:0] HOLD_LAST = 2'h1;

    typedef enum {SRC_NONE, SRC_EXC, SRC_FAST0, SRC_FAST1,
                  SRC_PER2, SRC_PER3} src_t;

    function automatic logic [1:0] nest_code(input rank_t r);
        case (r)
            3'h0: nest_code = 2'h0;
            3'h1: nest_code = 2'h1;
            3'h2: nest_code = 2'h2;
            default: nest_code = 2'h3;
        endcase
    endfunction
endpackage

// File: verilog/pick_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pick_if #(parameter int N = 8);
    logic [N-1:0] req;
    logic hit;
    logic [5:0] idx;
    modport picker(input req, output hit, output idx);
    modport user(output req, input hit, input idx);
endinterface
`default_nettype wire

// File: verilog/prio_pick.sv
`timescale 1ns/10ps
`default_nettype none
module prio_pick #(parameter int N = 8) (
    pick_if.picker p
);
    logic hit_v;
    logic [5:0] idx_v;

    // Lowest index wins, so lower vectors outrank higher ones
    always_comb begin
        hit_v = 1'b0;
        idx_v = 6'h00;
        for (int i = N - 1; i >= 0; i--) begin
            if (p.req[i]) begin
                hit_v = 1'b1;
                idx_v = 6'(i);
            end
        end
    end

    assign p.hit = hit_v;
    assign p.idx = idx_v;
endmodule
`default_nettype wire

// File: verilog/irq_ctrl.sv
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl import irq_pkg::*; #(
    parameter logic [20:0] RESET_VECTOR = 21'h000000
) (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CORE_RST,
    input wire logic [30:0] SRC_REQ,
    input wire logic [7:0] EXC_REQ,
    input wire logic [5:0] FAST0_VEC,
    input wire logic [20:0] FAST0_ADDR,
    input wire logic [5:0] FAST1_VEC,
    input wire logic [20:0] FAST1_ADDR,
    input wire logic [13:0] VECTOR_BASE,
    input wire logic [1:0] CORE_LEVEL,
    input wire logic CORE_ACK,
    output logic INT_REQ,
    output logic [1:0] NEST_LEVEL,
    output logic [20:0] VAB_OUT
);
    // ********************************************
    // State
    // ********************************************
    logic [15:0] ena2_r;
    logic [14:0] ena3_r;
    logic [3:0] prio_r;
    logic dis_r;
    logic [1:0] nest_fld_r;
    logic [6:0] vab_fld_r;
    logic int_r;
    logic [1:0] nest_r;
    logic [20:0] vab_r;
    logic [1:0] hold_r;
    logic [31:0] prdata_r;

    // ********************************************
    // Pending words
    // ********************************************
    logic [15:0] live2;
    logic [14:0] live3;
    logic [30:0] live_all;
    logic [15:0] pend2_word;
    logic [15:0] pend3_word;

    // Only enabled requests count as pending
    assign live2 = SRC_REQ[N_WORD2-1:0] & ena2_r;
    assign live3 = SRC_REQ[N_PERIPH-1:N_WORD2] & ena3_r;
    assign live_all = {live3, live2};
    assign pend2_word = ~live2;
    // Top bit has no vector behind it and reads idle
    assign pend3_word = {1'b1, ~live3};

    // ********************************************
    // Candidate pickers
    // ********************************************
    pick_if #(.N(N_EXC)) exc_p();
    pick_if #(.N(N_WORD2)) per2_p();
    pick_if #(.N(N_WORD3)) per3_p();

    // Exceptions bypass the enable words entirely
    assign exc_p.req = EXC_REQ;
    assign per2_p.req = live2;
    assign per3_p.req = live3;

    prio_pick #(.N(N_EXC)) u_exc (.p(exc_p));
    prio_pick #(.N(N_WORD2)) u_per2 (.p(per2_p));
    prio_pick #(.N(N_WORD3)) u_per3 (.p(per3_p));

    // ********************************************
    // Fast slots
    // ********************************************
    logic [4:0] f0_pos;
    logic [4:0] f1_pos;
    logic fast0_ok;
    logic fast1_ok;

    assign f0_pos = 5'(FAST0_VEC - VEC_LO2);
    assign f1_pos = 5'(FAST1_VEC - VEC_LO2);
    // A slot naming a vector below 33 never fires here
    assign fast0_ok = (FAST0_VEC >= VEC_LO2) && live_all[f0_pos];
    assign fast1_ok = (FAST1_VEC >= VEC_LO2) && live_all[f1_pos];

    // ********************************************
    // Arbitration
    // ********************************************
    rank_t exc_rank;
    rank_t rank2;
    rank_t rank3;
    rank_t sel_rank;
    src_t sel_src;
    logic [20:0] sel_vab;
    logic [5:0] sel_vec;

    assign exc_rank = EXC_RANKS[3*exc_p.idx +: 3];
    assign rank2 = 3'(prio_r[1:0]) + 3'h1;
    assign rank3 = 3'(prio_r[3:2]) + 3'h1;

    // Ties go to the earlier candidate in this chain
    always_comb begin
        sel_src = SRC_NONE;
        sel_rank = 3'h0;
        if (exc_p.hit) begin
            sel_src = SRC_EXC;
            sel_rank = exc_rank;
        end
        if (fast0_ok && (sel_src == SRC_NONE ||
                FAST_RANK > sel_rank)) begin
            sel_src = SRC_FAST0;
            sel_rank = FAST_RANK;
        end
        if (fast1_ok && (sel_src == SRC_NONE ||
                FAST_RANK > sel_rank)) begin
            sel_src = SRC_FAST1;
            sel_rank = FAST_RANK;
        end
        if (per2_p.hit && (sel_src == SRC_NONE ||
                rank2 > sel_rank)) begin
            sel_src = SRC_PER2;
            sel_rank = rank2;
        end
        if (per3_p.hit && (sel_src == SRC_NONE ||
                rank3 > sel_rank)) begin
            sel_src = SRC_PER3;
            sel_rank = rank3;
        end
    end

    always_comb begin
        sel_vec = 6'h00;
        case (sel_src)
            SRC_EXC: sel_vec = 6'(EXC_VEC_FIRST + exc_p.idx);
            SRC_PER2: sel_vec = 6'(VEC_LO2 + per2_p.idx);
            SRC_PER3: sel_vec = 6'(VEC_LO3 + per3_p.idx);
            default: sel_vec = 6'h00;
        endcase
    end

    // Fast slots jump straight to their own address
    assign sel_vab = (sel_src == SRC_FAST0) ? FAST0_ADDR :
                     (sel_src == SRC_FAST1) ? FAST1_ADDR :
                     {VECTOR_BASE, sel_vec, 1'b0};

    // ********************************************
    // Core handshake
    // ********************************************
    logic presenting;
    logic allowed;
    logic int_nxt;
    logic [1:0] nest_nxt;
    logic [20:0] vab_nxt;
    logic taken;

    assign presenting = RESET || CORE_RST || hold_r != HOLD_LAST;
    // Lowest trap may only run when nothing is nested
    assign allowed = sel_src != SRC_NONE && !dis_r &&
        (sel_rank > {1'b0, CORE_LEVEL} || CORE_LEVEL == 2'h0);
    assign int_nxt = allowed && !presenting;
    assign nest_nxt = int_nxt ? nest_code(sel_rank) : 2'h0;
    assign vab_nxt = presenting ? RESET_VECTOR : sel_vab;
    assign taken = CORE_ACK && int_r;

    always_ff @(posedge MCLK) begin
        if (RESET || CORE_RST) begin
            hold_r <= 2'h0;
        end else if (hold_r != HOLD_LAST) begin
            hold_r <= hold_r + 2'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            int_r <= 1'b0;
            nest_r <= 2'h0;
            vab_r <= RESET_VECTOR;
        end else begin
            int_r <= int_nxt;
            nest_r <= nest_nxt;
            vab_r <= vab_nxt;
        end
    end

    // Fields move only when the core enters a service routine
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            nest_fld_r <= CTRL_RESET[CTRL_NEST_HI:CTRL_NEST_LO];
            vab_fld_r <= CTRL_RESET[CTRL_VAB_HI:CTRL_VAB_LO];
        end else if (taken) begin
            nest_fld_r <= nest_r;
            vab_fld_r <= vab_r[7:1];
        end
    end

    assign INT_REQ = int_r;
    assign NEST_LEVEL = nest_r;
    assign VAB_OUT = vab_r;

    // ********************************************
    // APB slave
    // ********************************************
    logic [5:0] idx;
    logic setup;
    logic access;
    logic mapped;
    logic wr;
    logic [15:0] ctrl_word;
    logic [15:0] rd_word;

    assign idx = PADDR[ADDR_HI:ADDR_LO];
    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign mapped = idx == IDX_PEND2 || idx == IDX_PEND3 ||
                    idx == IDX_CTRL || idx == IDX_ENA2 ||
                    idx == IDX_ENA3 || idx == IDX_PRIO;
    assign wr = access && PWRITE;
    // Reserved bits read back fixed, whatever software wrote
    assign ctrl_word = {int_r, nest_fld_r, vab_fld_r,
                        dis_r, CTRL_RESV};
    assign rd_word = (idx == IDX_PEND2) ? pend2_word :
                     (idx == IDX_PEND3) ? pend3_word :
                     (idx == IDX_CTRL) ? ctrl_word :
                     (idx == IDX_ENA2) ? ena2_r :
                     (idx == IDX_ENA3) ? {1'b0, ena3_r} :
                     (idx == IDX_PRIO) ? {12'h000, prio_r} :
                     16'h0000;

    // Read data is latched in setup so it is ready for access
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            prdata_r <= 32'h00000000;
        end else if (setup && !PWRITE) begin
            prdata_r <= {16'h0000, rd_word};
        end
    end

    // Pending words and read-only fields have no write path
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            ena2_r <= 16'h0000;
            ena3_r <= 15'h0000;
            prio_r <= 4'h0;
            dis_r <= CTRL_RESET[CTRL_DIS_BIT];
        end else if (wr) begin
            if (idx == IDX_CTRL) begin
                dis_r <= PWDATA[CTRL_DIS_BIT];
            end
            if (idx == IDX_ENA2) begin
                ena2_r <= PWDATA[15:0];
            end
            if (idx == IDX_ENA3) begin
                ena3_r <= PWDATA[14:0];
            end
            if (idx == IDX_PRIO) begin
                prio_r <= PWDATA[3:0];
            end
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = access && !mapped;

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    rst_vec_out_a: assert property (
        CORE_RST |=> VAB_OUT == RESET_VECTOR)
        else $error("reset vector missing during core reset");

    rst_vec_hold_a: assert property (
        $fell(CORE_RST) |-> ##1 VAB_OUT == RESET_VECTOR)
        else $error("reset vector dropped before second edge");

    global_mask_a: assert property (
        dis_r |=> !INT_REQ)
        else $error("request sent while globally masked");

    pend_active_low_a: assert property (
        setup && !PWRITE && idx == IDX_PEND2
        |=> PRDATA[15:0] == ~$past(live2))
        else $error("pending word two not active low");

    ctrl_int_rd_a: assert property (
        setup && !PWRITE && idx == IDX_CTRL
        |=> PRDATA[CTRL_INT_BIT] == $past(INT_REQ)
            && PRDATA[4:0] == CTRL_RESV)
        else $error("control read mismatches request state");

    field_stable_a: assert property (
        !(CORE_ACK && INT_REQ)
        |=> $stable(nest_fld_r) && $stable(vab_fld_r))
        else $error("fields changed without service entry");

    field_load_a: assert property (
        CORE_ACK && INT_REQ |=> vab_fld_r == $past(VAB_OUT[7:1])
            && nest_fld_r == $past(NEST_LEVEL))
        else $error("fields not loaded on service entry");

    fast_order_a: assert property (
        fast0_ok && fast1_ok |-> sel_src != SRC_FAST1)
        else $error("fast slot 1 chosen over slot 0");

    vec_base_a: assert property (
        int_nxt && sel_src != SRC_FAST0 && sel_src != SRC_FAST1
        |=> VAB_OUT[20:7] == $past(VECTOR_BASE) && INT_REQ)
        else $error("vector base not above low bits");
endmodule
`default_nettype wire

// File: verif/core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Processor core side: takes one request
// ****************************************
module core_model (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic INT_REQ,
    input wire logic [1:0] NEST_LEVEL,
    input wire logic [20:0] VAB_OUT,
    input wire logic ack_en,
    input wire logic rti,
    input wire logic [3:0] delay,
    output logic CORE_ACK,
    output logic [1:0] CORE_LEVEL,
    output logic [20:0] taken_vab,
    output logic [7:0] taken_cnt
);
    logic busy_r;
    logic [3:0] wait_r;
    // Busy until return, so a still-high request is not taken twice
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            CORE_ACK <= 1'b0;
            CORE_LEVEL <= 2'h0;
            taken_vab <= 21'h0;
            taken_cnt <= 8'h0;
            busy_r <= 1'b0;
            wait_r <= 4'h0;
        end else begin
            CORE_ACK <= 1'b0;
            if (CORE_ACK) begin
                taken_vab <= VAB_OUT;
                CORE_LEVEL <= NEST_LEVEL;
                taken_cnt <= taken_cnt + 8'h01;
            end
            if (rti) begin
                busy_r <= 1'b0;
                CORE_LEVEL <= 2'h0;
            end else if (INT_REQ && ack_en && !busy_r) begin
                if (wait_r == delay) begin
                    CORE_ACK <= 1'b1;
                    busy_r <= 1'b1;
                    wait_r <= 4'h0;
                end else begin
                    wait_r <= wait_r + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: verif/irq_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_tb import irq_pkg::*;;
    localparam logic [20:0] RV = 21'h0a5a5a;
    localparam logic [13:0] BASE = 14'h2b3c;
    // Nesting code per exception slot, slot 0 in the low pair
    localparam logic [15:0] EXC_CODES = 16'h1bff;
    logic MCLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CORE_RST;
    logic CORE_ACK, INT_REQ, ack_en, rti, err;
    logic [7:0] PADDR, EXC_REQ, taken_cnt;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [30:0] SRC_REQ;
    logic [5:0] FAST0_VEC, FAST1_VEC;
    logic [20:0] FAST0_ADDR, FAST1_ADDR, VAB_OUT, taken_vab;
    logic [1:0] CORE_LEVEL, NEST_LEVEL;
    logic [3:0] delay;
    int errors, checks;
    irq_ctrl #(.RESET_VECTOR(RV)) irq_ctrl_i (.MCLK, .RESET, .PSEL,
        .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .CORE_RST, .SRC_REQ, .EXC_REQ, .FAST0_VEC, .FAST0_ADDR, .FAST1_VEC,
        .FAST1_ADDR, .VECTOR_BASE(BASE), .CORE_LEVEL, .CORE_ACK, .INT_REQ,
        .NEST_LEVEL, .VAB_OUT);
    core_model core_model_i (.MCLK, .RESET, .INT_REQ, .NEST_LEVEL, .VAB_OUT,
        .ack_en, .rti, .delay, .CORE_ACK, .CORE_LEVEL, .taken_vab, .taken_cnt);
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task complete_run;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= {idx, 2'h0};
        PWDATA <= {16'h0, wd};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            complete_run;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task rdchk(input logic [5:0] idx, input logic [15:0] exp);
        xfer(1'b0, idx, 16'h0);
        cmp(rd, {16'h0, exp});
    endtask
    // Bounded wait for the request line
    task waitreq;
        int n;
        n = 0;
        while (INT_REQ !== 1'b1 && n < 40) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        if (n >= 40) begin
            errors++;
            complete_run;
        end
    endtask
    // Let the core take one request, check it, then return from it
    task serve(input logic [20:0] ev, input logic [1:0] code);
        logic [7:0] c0;
        int n;
        c0 = taken_cnt;
        n = 0;
        @(posedge MCLK);
        ack_en <= 1'b1;
        while (taken_cnt === c0 && n < 60) begin
            @(posedge MCLK);
            #1;
            n++;
        end
        if (n >= 60) begin
            errors++;
            complete_run;
        end
        cmp({11'h0, taken_vab}, {11'h0, ev});
        cmp({30'h0, CORE_LEVEL}, {30'h0, code});
        xfer(1'b0, IDX_CTRL, 16'h0);
        cmp({23'h0, rd[14:6]}, {23'h0, code, ev[7:1]});
        @(posedge MCLK);
        ack_en <= 1'b0;
        SRC_REQ <= 31'h0;
        EXC_REQ <= 8'h0;
        rti <= 1'b1;
        @(posedge MCLK);
        rti <= 1'b0;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        errors = 0;
        checks = 0;
        RESET = 1'b1;
        {PSEL, PENABLE, PWRITE, CORE_RST, ack_en, rti} = 6'h0;
        PADDR = 8'h0;
        PWDATA = 32'h0;
        SRC_REQ = 31'h0;
        EXC_REQ = 8'h0;
        FAST0_VEC = 6'h28;
        FAST1_VEC = 6'h29;
        FAST0_ADDR = 21'h1f0a6;
        FAST1_ADDR = 21'h0c35a;
        delay = 4'h0;
        repeat (8) @(posedge MCLK);
        RESET <= 1'b0;
        #1;
        cmp({11'h0, VAB_OUT}, {11'h0, RV});
        @(posedge MCLK);
        #1;
        cmp({11'h0, VAB_OUT}, {11'h0, RV});
        rdchk(IDX_CTRL, 16'h001c);
        rdchk(IDX_PEND3, 16'hffff);
        xfer(1'b0, 6'h3f, 16'h0);
        cmp({31'h0, err}, 32'h1);
        cmp(rd, 32'h0);
        @(posedge MCLK);
        SRC_REQ <= 31'h7fffffff;
        xfer(1'b1, IDX_PEND2, 16'h0000);
        rdchk(IDX_PEND2, 16'hffff);
        cmp({31'h0, INT_REQ}, 32'h0);
        xfer(1'b1, IDX_CTRL, 16'hfffc);
        rdchk(IDX_CTRL, 16'h003c);
        xfer(1'b1, IDX_ENA2, 16'hffff);
        xfer(1'b1, IDX_ENA3, 16'h7fff);
        for (int i = 0; i < 31; i++) begin
            @(posedge MCLK);
            SRC_REQ <= 31'h1 << i;
            rdchk(IDX_PEND2, ~(i < 16 ? 16'h1 << i : 16'h0));
            rdchk(IDX_PEND3, ~(i > 15 ? 16'h1 << (i - 16) : 16'h0));
            #1;
            cmp({31'h0, INT_REQ}, 32'h0);
        end
        @(posedge MCLK);
        SRC_REQ <= 31'h0;
        xfer(1'b1, IDX_CTRL, 16'h001c);
        for (int j = 0; j < 8; j++) begin
            @(posedge MCLK);
            EXC_REQ <= 8'h1 << j;
            serve({BASE, 6'(j + 1), 1'b0}, EXC_CODES[2 * j +: 2]);
        end
        for (int l = 0; l < 4; l++) begin
            xfer(1'b1, IDX_PRIO, {12'h0, 2'(l), 2'(l)});
            @(posedge MCLK);
            SRC_REQ <= 31'h1;
            serve({BASE, 6'h21, 1'b0}, l == 3 ? 2'h3 : 2'(l + 1));
            @(posedge MCLK);
            SRC_REQ <= 31'h1 << 17;
            serve({BASE, 6'h32, 1'b0}, l == 3 ? 2'h3 : 2'(l + 1));
        end
        @(posedge MCLK);
        SRC_REQ <= 31'h2;
        waitreq;
        xfer(1'b0, IDX_CTRL, 16'h0);
        cmp({23'h0, rd[14:6]}, {23'h0, 2'h3, 7'h32});
        serve({BASE, 6'h22, 1'b0}, 2'h3);
        xfer(1'b1, IDX_PRIO, 16'h000a);
        @(posedge MCLK);
        SRC_REQ <= (31'h1 << 7) | (31'h1 << 8);
        delay <= 4'h3;
        serve(FAST0_ADDR, 2'h3);
        @(posedge MCLK);
        SRC_REQ <= 31'h1 << 8;
        serve(FAST1_ADDR, 2'h3);
        xfer(1'b1, IDX_CTRL, 16'h003c);
        @(posedge MCLK);
        EXC_REQ <= 8'h40;
        repeat (10) @(posedge MCLK);
        #1;
        cmp({31'h0, INT_REQ}, 32'h0);
        xfer(1'b1, IDX_CTRL, 16'h001c);
        waitreq;
        xfer(1'b0, IDX_CTRL, 16'h0);
        cmp({31'h0, rd[15]}, 32'h1);
        serve({BASE, 6'h07, 1'b0}, 2'h1);
        @(posedge MCLK);
        EXC_REQ <= 8'h80;
        CORE_RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        #1;
        cmp({INT_REQ, 10'h0, VAB_OUT}, {11'h0, RV});
        @(posedge MCLK);
        CORE_RST <= 1'b0;
        @(posedge MCLK);
        #1;
        cmp({11'h0, VAB_OUT}, {11'h0, RV});
        serve({BASE, 6'h08, 1'b0}, 2'h0);
        complete_run;
    end
endmodule
`default_nettype wire
